//--- sfc_consts.svh
// Purpose: constants of the serial flash command front end
// Assumes: included by bare name
// Notes: opcodes, status field positions, reset values, identity bytes
`ifndef SFC_CONSTS_SVH
`define SFC_CONSTS_SVH
// ********************
// opcodes
// ********************
`define SFC_OP_RST_ARM  8'h66
`define SFC_OP_RST_GO   8'h99
`define SFC_OP_QUAD_IN  8'h38
`define SFC_OP_QUAD_OUT 8'hFF
`define SFC_OP_WR_EN    8'h06
`define SFC_OP_WR_DIS   8'h04
`define SFC_OP_VOL_EN   8'h50
`define SFC_OP_ST1_RD   8'h05
`define SFC_OP_ST2_RDA  8'h09
`define SFC_OP_ST2_RDB  8'h35
`define SFC_OP_ST3_RDA  8'h95
`define SFC_OP_ST3_RDB  8'h15
`define SFC_OP_ST_WR    8'h01
`define SFC_OP_ST2_WR   8'h31
`define SFC_OP_ST3_WRA  8'hC0
`define SFC_OP_ST3_WRB  8'h11
`define SFC_OP_SLEEP    8'hB9
`define SFC_OP_WAKE_ID  8'hAB
`define SFC_OP_MID_1    8'h90
`define SFC_OP_MID_2    8'h92
`define SFC_OP_MID_4    8'h94
`define SFC_OP_JID      8'h9F
`define SFC_OP_EXT_RD   8'hC8
`define SFC_OP_EXT_WR   8'hC5
`define SFC_OP_A4_ON    8'hB7
`define SFC_OP_A4_OFF   8'hE9
`define SFC_OP_PG       8'h02
`define SFC_OP_PG4      8'h12
`define SFC_OP_QPG      8'h32
`define SFC_OP_QPG4     8'h34
`define SFC_OP_SCL      8'h20
`define SFC_OP_HCL      8'h52
`define SFC_OP_BCL      8'hD8
`define SFC_OP_SCL4     8'h21
`define SFC_OP_HCL4     8'h5C
`define SFC_OP_BCL4     8'hDC
// ********************
// fields, resets, identity
// ********************
`define SFC_S1_BUSY     0
`define SFC_S1_WEL      1
`define SFC_S1_BP_LSB   2
`define SFC_S1_TB       6
`define SFC_S2_CMP      6
`define SFC_S1_WMASK    8'hFC
`define SFC_SR_RST      8'h00
`define SFC_EXT_RST     8'h00
`define SFC_MAKER_ID    8'h5A // arbitrary value
`define SFC_DEV_ID      8'hA5 // arbitrary value
`define SFC_JID_HI      8'h3C // arbitrary value
`define SFC_JID_LO      8'hC3 // arbitrary value
`endif

//--- sfc_front_end.sv
// Purpose: instruction front end of a serial nor flash, sampled by the system clock
// Assumes: link clock at most a quarter of the system clock; array side on clock
// Notes on behaviour
// - all opcode, address and data bits move most significant bit first.
// - after select falls, sample on every rising edge; first byte is the opcode.
// - read commands drive data out after input; host may stop after any bit.
// - write commands run only if the bit count is a multiple of eight.
// - page program ending in a partial byte does nothing, latch stays set.
// - page programs and wake-with-id need their minimum byte count.
// - page program needs address bytes plus at least one data byte.
// - erases need exactly the address length of the current mode; 21h, 5Ch and DCh always need four address bytes.
// - while the array is busy, program, erase and status writes are ignored.
// - program or erase touching a protected block is ignored.
// - 99h resets only straight after 66h; any other command disarms.
// - 38h enters quad mode, FFh leaves it, one byte in either width.
// - status reads return register 1, 2 or 3 repeatedly.
// - 01h writes one to three registers; 31h, C0h, 11h write one.
// - B9h sleeps; ABh plus three dummies wakes and repeats the id byte.
// - 90h/92h/94h after three bytes alternate maker and device codes.
// - C8h reads and C5h writes the extended address byte.
// - B7h selects four address bytes, E9h three.
// - modifying commands need the latch, status writes the latch or 50h; completion and 04h clear it.
// - complement, top/bottom and four level bits select the protected area.
// - asleep, only the wake command is obeyed.
// - after reset, three address bytes are used.
`timescale 1ns/1ps
`include "sfc_consts.svh"

// ********************
// program data buffer
// ********************
module sfc_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic         flush,
	// filling side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// draining side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   cnt_q;
	wire           push_w = in_valid & in_ready;
	wire           pop_w = out_valid & out_ready;
	// flags and read port; depth must be a power of two
	assign in_ready = cnt_q != D[AW:0];
	assign out_valid = cnt_q != '0;
	assign out_data = mem[rd_q];
	// pointers
	always_ff @(posedge clock) begin
		if (!rst_n || flush) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push_w) wr_q <= wr_q + 1'b1;
			if (pop_w) rd_q <= rd_q + 1'b1;
			cnt_q <= cnt_q + {{AW{1'b0}}, push_w} - {{AW{1'b0}}, pop_w};
		end
	end
	// storage
	always_ff @(posedge clock) begin
		if (push_w) mem[wr_q] <= in_data;
	end
endmodule // sfc_fifo

// ********************
// command front end
// ********************
module sfc_front_end (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// serial link
	input  wire logic       spi_sclk,
	input  wire logic       spi_cs_n,
	input  wire logic [3:0] spi_io_in,
	output logic [3:0]      spi_io_out_q,
	output logic [3:0]      spi_io_oe_q,
	// array side
	input  wire logic       array_busy,
	output logic            op_pulse_q,
	output sfc_pkg::sfc_op_e op_kind_q,
	output logic [31:0]     op_addr_q,
	output logic            soft_reset_q,
	// program data
	output logic            pgm_valid,
	input  wire logic       pgm_ready,
	output logic [7:0]      pgm_data,
	output logic            pgm_buf_ready_q,
	// state
	output logic [7:0]      status1_q,
	output logic [7:0]      status2_q,
	output logic [7:0]      status3_q,
	output logic [7:0]      ext_addr_q,
	output logic            write_enable_latch_q,
	output logic            deep_pd_q,
	output logic            quad_mode_q,
	output logic            addr4_q
);
	sfc_pkg::sfc_phase_e ph_q;
	logic [2:0] sclk_s;
	logic [2:0] cs_s;
	logic [3:0] io_s0;
	logic [3:0] io_s1;
	logic [7:0] op_q;
	logic [7:0] out_q;
	logic [31:0] arg_q;
	logic [5:0] nby_q;
	logic [2:0] bcnt_q;
	logic [2:0] obit_q;
	logic [1:0] oidx_q;
	logic       id_st_q;
	logic       arm_q;
	logic       vol_q;
	logic       flush_q;
	logic [7:0] sh_q;
	wire        fifo_in_ready_w;

	function automatic logic [5:0] rd_len(input logic [7:0] op);
		case (op)
			`SFC_OP_ST1_RD, `SFC_OP_ST2_RDA, `SFC_OP_ST2_RDB, `SFC_OP_ST3_RDA,
			`SFC_OP_ST3_RDB, `SFC_OP_EXT_RD, `SFC_OP_JID: rd_len = 6'h01;
			`SFC_OP_WAKE_ID, `SFC_OP_MID_1, `SFC_OP_MID_2, `SFC_OP_MID_4: rd_len = 6'h04;
			default: rd_len = 6'h00;
		endcase
	endfunction

	function automatic logic [7:0] rd_byte(input logic [7:0] op, input logic [1:0] idx,
		input logic st);
		case (op)
			`SFC_OP_ST1_RD: rd_byte = {status1_q[7:2], write_enable_latch_q, array_busy};
			`SFC_OP_ST2_RDA, `SFC_OP_ST2_RDB: rd_byte = status2_q;
			`SFC_OP_ST3_RDA, `SFC_OP_ST3_RDB: rd_byte = status3_q;
			`SFC_OP_EXT_RD: rd_byte = ext_addr_q;
			`SFC_OP_WAKE_ID: rd_byte = `SFC_DEV_ID;
			`SFC_OP_MID_1, `SFC_OP_MID_2, `SFC_OP_MID_4:
				rd_byte = (idx[0] ^ st) ? `SFC_DEV_ID : `SFC_MAKER_ID;
			`SFC_OP_JID: rd_byte = (idx == 2'h0) ? `SFC_MAKER_ID :
				(idx == 2'h1) ? `SFC_JID_HI : `SFC_JID_LO;
			default: rd_byte = 8'h00;
		endcase
	endfunction

	// protected area from complement, top/bottom and level bits
	function automatic logic prot_f(input logic cmp, input logic tb, input logic [3:0] bp,
		input logic [8:0] blk);
		logic [9:0] sz;
		logic       p;
		sz = 10'h001 << (bp - 4'h1);
		if (bp == 4'h0) p = 1'b0;
		else if (bp >= 4'hA) p = 1'b1;
		else if (tb) p = {1'b0, blk} < sz;
		else p = {1'b0, blk} >= (10'h200 - sz);
		prot_f = cmp ? ~p : p;
	endfunction

	// serial input shift by one line or by four lines
	function automatic logic [7:0] out_sh_in(input logic q);
		out_sh_in = q ? {sh_q[3:0], io_s1} : {sh_q[6:0], io_s1[0]};
	endfunction

	// edges of the synchronised link
	wire rise_w = sclk_s[1] & ~sclk_s[2] & ~cs_s[1];
	wire fall_w = ~sclk_s[1] & sclk_s[2] & ~cs_s[1];
	wire cs_rise_w = cs_s[1] & ~cs_s[2];
	// input shifting; quad page data and quad mode take nibbles
	wire is_qpg_w = (op_q == `SFC_OP_QPG) | (op_q == `SFC_OP_QPG4);
	wire is_pg_w = (op_q == `SFC_OP_PG) | (op_q == `SFC_OP_PG4) | is_qpg_w;
	wire is_er_w = (op_q == `SFC_OP_SCL) | (op_q == `SFC_OP_HCL) | (op_q == `SFC_OP_BCL) |
		(op_q == `SFC_OP_SCL4) | (op_q == `SFC_OP_HCL4) | (op_q == `SFC_OP_BCL4);
	wire op4_w = (op_q == `SFC_OP_PG4) | (op_q == `SFC_OP_QPG4) | (op_q == `SFC_OP_SCL4) |
		(op_q == `SFC_OP_HCL4) | (op_q == `SFC_OP_BCL4);
	wire use4_w = addr4_q | op4_w;
	wire [5:0] alen_w = use4_w ? 6'h05 : 6'h04;
	wire [5:0] lim_w = (is_pg_w | is_er_w) ? alen_w : 6'h05;
	wire quad_in_w = quad_mode_q | (ph_q == sfc_pkg::PH_IN && is_qpg_w && nby_q >= alen_w);
	wire [7:0] nsh_w = quad_in_w ? {out_sh_in(1'b1)} : {out_sh_in(1'b0)};
	wire [3:0] bsum_w = {1'b0, bcnt_q} + (quad_in_w ? 4'h4 : 4'h1);
	wire [7:0] cur_op_w = (ph_q == sfc_pkg::PH_OP) ? nsh_w : op_q;
	wire rd_go_w = bsum_w[3] && rd_len(cur_op_w) != 6'h00 &&
		(nby_q + 6'h01 == rd_len(cur_op_w)) &&
		(!deep_pd_q || cur_op_w == `SFC_OP_WAKE_ID);
	wire push_w = rise_w && bsum_w[3] && ph_q == sfc_pkg::PH_IN && is_pg_w &&
		nby_q >= alen_w && !deep_pd_q;

	// output width and placement
	wire [3:0] ow_w = (quad_mode_q || op_q == `SFC_OP_MID_4) ? 4'h4 :
		(op_q == `SFC_OP_MID_2) ? 4'h2 : 4'h1;
	wire [3:0] osum_w = {1'b0, obit_q} + ow_w;
	wire [7:0] oshl_w = (ow_w == 4'h4) ? {out_q[3:0], 4'h0} :
		(ow_w == 4'h2) ? {out_q[5:0], 2'b00} : {out_q[6:0], 1'b0};
	wire [3:0] place_w = (ow_w == 4'h4) ? out_q[7:4] :
		(ow_w == 4'h2) ? {2'b00, out_q[7:6]} : {2'b00, out_q[7], 1'b0};
	wire [3:0] oe_w = (ow_w == 4'h4) ? 4'hF : (ow_w == 4'h2) ? 4'h3 : 4'h2;
	wire [1:0] nidx_w = (op_q == `SFC_OP_JID && oidx_q == 2'h2) ? 2'h0 : oidx_q + 2'h1;

	// end-of-frame checks
	wire fin_w = cs_rise_w && nby_q != 6'h00;
	wire al_w = bcnt_q == 3'h0;
	wire one_w = fin_w && al_w && nby_q == 6'h01 && !deep_pd_q;
	wire [8:0] blk_w = use4_w ? arg_q[24:16] : {ext_addr_q[0], arg_q[23:16]};
	wire prot_w = prot_f(status2_q[`SFC_S2_CMP], status1_q[`SFC_S1_TB],
		status1_q[`SFC_S1_BP_LSB+3:`SFC_S1_BP_LSB], blk_w);
	wire wok_w = fin_w && al_w && write_enable_latch_q && !array_busy && !deep_pd_q;
	wire pg_ok_w = is_pg_w && wok_w && nby_q > alen_w && !prot_w;
	wire er_ok_w = is_er_w && wok_w && nby_q == alen_w && !prot_w;
	wire sw1_w = op_q == `SFC_OP_ST_WR;
	wire sw3_w = (op_q == `SFC_OP_ST3_WRA) || (op_q == `SFC_OP_ST3_WRB);
	wire sw_ok_w = fin_w && al_w && !array_busy && !deep_pd_q &&
		(write_enable_latch_q || vol_q) && ((sw1_w && nby_q >= 6'h02 && nby_q <= 6'h04) ||
		((op_q == `SFC_OP_ST2_WR || sw3_w) && nby_q == 6'h02));
	wire go_w = pg_ok_w || er_ok_w || sw_ok_w;
	sfc_pkg::sfc_op_e kind_w;
	assign kind_w = sw_ok_w ? sfc_pkg::OP_SR : pg_ok_w ? (is_qpg_w ? sfc_pkg::OP_QPGM :
		sfc_pkg::OP_PGM) : (op_q == `SFC_OP_SCL || op_q == `SFC_OP_SCL4) ? sfc_pkg::OP_SEC :
		(op_q == `SFC_OP_HCL || op_q == `SFC_OP_HCL4) ? sfc_pkg::OP_HALF : sfc_pkg::OP_BLK;

	// two-flop synchronisers for the link
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sclk_s <= 3'h0;
			cs_s <= 3'h7;
			io_s0 <= 4'h0;
			io_s1 <= 4'h0;
		end else begin
			sclk_s <= {sclk_s[1:0], spi_sclk};
			cs_s <= {cs_s[1:0], spi_cs_n};
			io_s0 <= spi_io_in;
			io_s1 <= io_s0;
		end
	end

	// framing: opcode, arguments and data-out shifting
	always_ff @(posedge clock) begin
		if (!rst_n || cs_s[1]) begin
			ph_q <= sfc_pkg::PH_IDLE;
			{sh_q, bcnt_q, nby_q, obit_q, oidx_q, id_st_q} <= '0;
			spi_io_oe_q <= 4'h0;
			spi_io_out_q <= 4'h0;
			if (!rst_n) {op_q, arg_q, out_q} <= '0;
		end else if (ph_q == sfc_pkg::PH_IDLE) begin
			ph_q <= sfc_pkg::PH_OP;
		end else if (ph_q == sfc_pkg::PH_OUT) begin
			if (fall_w) begin
				spi_io_out_q <= place_w;
				spi_io_oe_q <= oe_w;
				out_q <= osum_w[3] ? rd_byte(op_q, nidx_w, id_st_q) : oshl_w;
				obit_q <= osum_w[2:0];
				if (osum_w[3]) oidx_q <= nidx_w;
			end
		end else if (rise_w) begin
			sh_q <= nsh_w;
			bcnt_q <= bsum_w[2:0];
			if (bsum_w[3]) begin
				if (nby_q != 6'h3F) nby_q <= nby_q + 6'h01;
				if (ph_q == sfc_pkg::PH_OP) begin
					op_q <= nsh_w;
					ph_q <= sfc_pkg::PH_IN;
				end else if (nby_q < lim_w) begin
					arg_q <= {arg_q[23:0], nsh_w};
				end
				if (rd_go_w) begin
					ph_q <= sfc_pkg::PH_OUT;
					out_q <= rd_byte(cur_op_w, 2'h0, nsh_w == 8'h01);
					id_st_q <= nsh_w == 8'h01;
				end
			end
		end
	end

	// command execution at the end of the frame
	always_ff @(posedge clock) begin
		op_pulse_q <= 1'b0;
		soft_reset_q <= 1'b0;
		flush_q <= 1'b0;
		pgm_buf_ready_q <= fifo_in_ready_w;
		if (!rst_n || soft_reset_q) begin
			{write_enable_latch_q, quad_mode_q, addr4_q, arm_q, vol_q} <= '0;
			ext_addr_q <= `SFC_EXT_RST;
			op_kind_q <= sfc_pkg::OP_NONE;
			if (!rst_n) begin
				{deep_pd_q, op_addr_q, pgm_buf_ready_q} <= '0;
				{status1_q, status2_q, status3_q} <= {3{`SFC_SR_RST}};
			end
		end else if (fin_w) begin
			arm_q <= one_w && op_q == `SFC_OP_RST_ARM;
			vol_q <= one_w && op_q == `SFC_OP_VOL_EN;
			soft_reset_q <= one_w && op_q == `SFC_OP_RST_GO && arm_q;
			flush_q <= is_pg_w && !pg_ok_w;
			if (go_w) begin
				op_pulse_q <= 1'b1;
				op_kind_q <= kind_w;
				op_addr_q <= {use4_w ? arg_q[31:24] : ext_addr_q, arg_q[23:0]};
				write_enable_latch_q <= 1'b0;
			end
			if (sw_ok_w && sw1_w) begin
				case (nby_q)
					6'h02: status1_q <= arg_q[7:0] & `SFC_S1_WMASK;
					6'h03: {status1_q, status2_q} <= {arg_q[15:8] & `SFC_S1_WMASK, arg_q[7:0]};
					default: {status1_q, status2_q, status3_q} <=
						{arg_q[23:16] & `SFC_S1_WMASK, arg_q[15:0]};
				endcase
			end else if (sw_ok_w) begin
				if (sw3_w) status3_q <= arg_q[7:0];
				else status2_q <= arg_q[7:0];
			end
			if (fin_w && al_w && op_q == `SFC_OP_WAKE_ID && nby_q >= 6'h04)
				deep_pd_q <= 1'b0;
			if (one_w) begin
				case (op_q)
					`SFC_OP_WR_EN: write_enable_latch_q <= 1'b1;
					`SFC_OP_WR_DIS: write_enable_latch_q <= 1'b0;
					`SFC_OP_SLEEP: deep_pd_q <= 1'b1;
					`SFC_OP_A4_ON: addr4_q <= 1'b1;
					`SFC_OP_A4_OFF: addr4_q <= 1'b0;
					`SFC_OP_QUAD_IN: quad_mode_q <= 1'b1;
					`SFC_OP_QUAD_OUT: quad_mode_q <= 1'b0;
					default: ; // unknown opcode: nothing
				endcase
			end
			if (fin_w && al_w && !deep_pd_q && op_q == `SFC_OP_EXT_WR && nby_q == 6'h02)
				ext_addr_q <= arg_q[7:0];
		end
	end

	sfc_fifo #(.W(8), .D(16)) u_fifo (
		.clock(clock), .rst_n(rst_n), .flush(flush_q),
		.in_valid(push_w), .in_ready(fifo_in_ready_w), .in_data(nsh_w),
		.out_valid(pgm_valid), .out_ready(pgm_ready), .out_data(pgm_data)
	);

	// ********************
	// checks
	// ********************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	wel_clear_a: assert property (op_pulse_q |-> !write_enable_latch_q)
		else $error("latch still set after operation");
	wel_needed_a: assert property (op_pulse_q && op_kind_q != sfc_pkg::OP_SR |->
		$past(write_enable_latch_q)) else $error("operation without latch");
	busy_block_a: assert property (op_pulse_q |-> !$past(array_busy))
		else $error("operation while busy");
	prot_block_a: assert property (op_pulse_q && op_kind_q != sfc_pkg::OP_SR |->
		!$past(prot_w)) else $error("protected block touched");
	byte_align_a: assert property (op_pulse_q |-> $past(bcnt_q) == 3'h0)
		else $error("operation on partial byte");
	erase_len_a: assert property (op_pulse_q && op_kind_q >= sfc_pkg::OP_SEC &&
		op_kind_q <= sfc_pkg::OP_BLK |-> $past(nby_q) == $past(alen_w))
		else $error("erase with wrong length");
	pgm_len_a: assert property (op_pulse_q && (op_kind_q == sfc_pkg::OP_PGM ||
		op_kind_q == sfc_pkg::OP_QPGM) |-> $past(nby_q) > $past(alen_w))
		else $error("program without data byte");
	sleep_quiet_a: assert property ($past(deep_pd_q) |-> !op_pulse_q)
		else $error("operation while asleep");
	reset_arm_a: assert property (soft_reset_q |-> $past(arm_q, 2))
		else $error("reset without arming");
	msb_out_a: assert property (fall_w && ph_q == sfc_pkg::PH_OUT && ow_w == 4'h1 |=>
		spi_io_out_q[1] == $past(out_q[7])) else $error("output bit order");
	c_pgm: cover property (op_pulse_q && op_kind_q == sfc_pkg::OP_PGM);
	c_reset: cover property (soft_reset_q);
	c_sleep: cover property ($rose(deep_pd_q) ##[1:1000] $fell(deep_pd_q));
endmodule // sfc_front_end

//--- sfc_host_model.sv
// Purpose: behavioural host controller that drives the serial link
// Assumes: mode 0, link clock of 160 ns made from the 20 ns system clock
// Notes: lines the host no longer uses show the inverse of their last value
`timescale 1ns/1ps

// ********************
// host model
// ********************
module sfc_host_model (
	// system clock
	input  wire logic       clock,
	// serial link
	output logic            sclk,
	output logic            cs_n,
	output logic [3:0]      drv,
	input  wire logic [3:0] io
);
	// link idles with clock low and select high
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		drv  = 4'h0;
	end

	// one frame: n bits from the top of v, w lines per edge, then r bits read back
	task automatic frame(input logic [255:0] v, input int n, input int w, input int r,
		output logic [31:0] rd);
		int i;
		rd = 32'h0;
		@(posedge clock);
		#1 cs_n = 1'b0;
		for (i = 0; i < n / w + r; i++) begin
			if (i < n / w && w == 4)
				drv = v[255 - 4 * i -: 4]; // nibble per edge
			else if (i < n / w)
				drv = {~drv[3:1], v[255 - i]}; // top bit first
			else
				drv = ~drv; // input phase over, lines driven to the inverse of their last value
			repeat (4) @(posedge clock);
			#1 sclk = 1'b1;
			repeat (4) @(posedge clock);
			#1;
			if (i >= n / w)
				rd = {rd[30:0], io[1]}; // may stop after any bit
			sclk = 1'b0;
		end
		// select rises only after the last bit
		repeat (2) @(posedge clock);
		#1 cs_n = 1'b1;
		drv = ~drv;
		repeat (8) @(posedge clock);
		#1;
	endtask
endmodule // sfc_host_model

//--- sfc_pkg.sv
// Purpose: types of the serial flash command front end
// Assumes: nothing
// Notes: frame phases and array operation kinds
package sfc_pkg;
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_OP   = 2'b01,
		PH_IN   = 2'b10,
		PH_OUT  = 2'b11
	} sfc_phase_e;
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_PGM  = 3'b001,
		OP_QPGM = 3'b010,
		OP_SEC  = 3'b011,
		OP_HALF = 3'b100,
		OP_BLK  = 3'b101,
		OP_SR   = 3'b110
	} sfc_op_e;
endpackage

//--- tb.sv
// Purpose: self-checking bench of the command front end
// Assumes: host model on the link, bench as array and buffer sink
// Notes: pulses and drained bytes are matched against queued notes
`timescale 1ns/1ps
`include "sfc_consts.svh"

// ********************
// bench top
// ********************
module tb;
	logic        clock, rst_n, array_busy, pgm_ready, sink_on, sclk, cs_n;
	logic        op_pulse_q, soft_reset_q, pgm_valid, pgm_buf_ready_q;
	logic        write_enable_latch_q, deep_pd_q, quad_mode_q, addr4_q;
	logic [3:0]  drv, io_in, io_out, io_oe;
	logic [7:0]  pgm_data, status1_q, status2_q, status3_q, ext_addr_q;
	logic [31:0] op_addr_q, rd, addr;
	logic [35:0] note, seen;
	logic [255:0] v;
	logic [35:0] note_q[$];
	logic [8:0]  byte_q[$];
	int          err_total, checked, seed, i;
	sfc_pkg::sfc_op_e op_kind_q;
	logic [7:0]  rop [5] = '{8'h05, 8'h09, 8'h35, 8'h95, 8'h15};
	logic [7:0]  eop [3] = '{8'h20, 8'h52, 8'hD8};
	sfc_pkg::sfc_op_e ek [3] = '{sfc_pkg::OP_SEC, sfc_pkg::OP_HALF, sfc_pkg::OP_BLK};

	// clock and wire resolution
	initial clock = 1'b0;
	always #10 clock = ~clock;
	assign io_in = (io_oe & io_out) | (~io_oe & drv);

	sfc_host_model host (.clock(clock), .sclk(sclk), .cs_n(cs_n), .drv(drv), .io(io_in));
	sfc_front_end dut (.clock(clock), .rst_n(rst_n), .spi_sclk(sclk), .spi_cs_n(cs_n),
		.spi_io_in(io_in), .spi_io_out_q(io_out), .spi_io_oe_q(io_oe),
		.array_busy(array_busy), .op_pulse_q(op_pulse_q), .op_kind_q(op_kind_q),
		.op_addr_q(op_addr_q), .soft_reset_q(soft_reset_q), .pgm_valid(pgm_valid),
		.pgm_ready(pgm_ready), .pgm_data(pgm_data), .pgm_buf_ready_q(pgm_buf_ready_q),
		.status1_q(status1_q), .status2_q(status2_q), .status3_q(status3_q),
		.ext_addr_q(ext_addr_q), .write_enable_latch_q(write_enable_latch_q),
		.deep_pd_q(deep_pd_q), .quad_mode_q(quad_mode_q), .addr4_q(addr4_q));

	task automatic check(input logic [63:0] s, input logic [63:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic cmd(input logic [63:0] val, input int n);
		host.frame({192'h0, val} << (256 - n), n, 1, 0, rd);
	endtask
	task automatic op(input sfc_pkg::sfc_op_e k, input logic [31:0] a);
		note_q.push_back({1'b0, k, a});
	endtask
	task automatic done(input string s);
		$display("test %0s done", s);
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// sink stalls at random while enabled
	always @(posedge clock) #1 pgm_ready = sink_on && ($urandom % 3 != 0);

	// monitor: pulses and drained bytes against oldest notes, off the launching edge
	always @(negedge clock) begin
		if (rst_n && (op_pulse_q || soft_reset_q)) begin
			note = (note_q.size() > 0) ? note_q.pop_front() : '1;
			seen = soft_reset_q ? 36'h8_0000_0000 : {1'b0, op_kind_q, op_addr_q};
			if (!soft_reset_q && op_kind_q == sfc_pkg::OP_SR)
				seen[31:0] = 32'h0;
			check(seen, note);
		end
		if (rst_n && pgm_valid && pgm_ready)
			check({1'b0, pgm_data}, (byte_q.size() > 0) ? byte_q.pop_front() : 9'h1FF);
	end

	// watchdog
	initial begin
		repeat (40000) @(posedge clock);
		err_total++;
		stop_test();
	end

	// main sequence
	initial begin
		rst_n = 1'b0;
		array_busy = 1'b0;
		sink_on = 1'b0;
		err_total = 0;
		checked = 0;
		repeat (5) @(posedge clock);
		#1 rst_n = 1'b1;
		seed = $urandom(32'h30dd);
		repeat (4) @(posedge clock);
		check({write_enable_latch_q, deep_pd_q, addr4_q, status1_q, ext_addr_q}, 0);
		done("reset");
		cmd(8'hB9, 8);
		cmd(8'h06, 8);
		check({deep_pd_q, write_enable_latch_q}, 2'b10);
		host.frame({32'hAB00_0000, 224'h0}, 32, 1, 8, rd);
		check({deep_pd_q, rd[7:0]}, {1'b0, `SFC_DEV_ID});
		for (i = 0; i < 2; i++) begin
			host.frame({8'h90, 16'h0, i[7:0], 224'h0}, 32, 1, 16, rd);
			check(rd[15:0], i ? {`SFC_DEV_ID, `SFC_MAKER_ID} : {`SFC_MAKER_ID, `SFC_DEV_ID});
		end
		cmd(8'h06, 8);
		for (i = 0; i < 5; i++) begin
			host.frame({rop[i], 248'h0}, 8, 1, 16, rd);
			check(rd[15:0], (i == 0) ? 16'h0202 : 16'h0000);
		end
		done("identity and status");
		// partial byte, then address without data: both dropped
		cmd({8'h02, 24'h000100, 8'hA5, 3'h5}, 43);
		cmd({8'h02, 24'h000100}, 32);
		check(write_enable_latch_q, 1'b1);
		addr = {8'h00, 24'($urandom)};
		v = {8'h02, addr[23:0], 224'h0};
		for (i = 0; i < 16; i++) begin
			v[223 - 8 * i -: 8] = 8'($urandom);
			byte_q.push_back({1'b0, v[223 - 8 * i -: 8]});
		end
		op(sfc_pkg::OP_PGM, addr);
		host.frame(v, 160, 1, 0, rd);
		check({pgm_buf_ready_q, write_enable_latch_q}, 2'b00);
		sink_on = 1'b1;
		for (i = 0; i < 300 && byte_q.size() > 0; i++)
			@(posedge clock);
		check(byte_q.size(), 0);
		done("program");
		cmd(8'h06, 8);
		cmd({8'h20, 32'h0001_0000}, 40);
		array_busy = 1'b1;
		cmd({8'h20, 24'h010000}, 32);
		array_busy = 1'b0;
		check(write_enable_latch_q, 1'b1);
		for (i = 0; i < 3; i++) begin
			cmd(8'h06, 8);
			addr = {8'h00, 24'($urandom)};
			op(ek[i], addr);
			cmd({eop[i], addr[23:0]}, 32);
		end
		cmd({8'hD8, 24'h0}, 32);
		done("erase");
		cmd(8'h06, 8);
		cmd({8'hC5, 8'h01}, 16);
		op(sfc_pkg::OP_SR, 32'h0);
		cmd({8'h01, 8'h04}, 16);
		check({status1_q, ext_addr_q, write_enable_latch_q}, {16'h0401, 1'b0});
		cmd(8'h06, 8);
		cmd({8'h20, 24'hFF0000}, 32);
		op(sfc_pkg::OP_SEC, 32'h01FE_0000);
		cmd({8'h20, 24'hFE0000}, 32);
		cmd(8'hB7, 8);
		cmd(8'h06, 8);
		op(sfc_pkg::OP_SEC, 32'h0002_0000);
		cmd({8'h20, 32'h0002_0000}, 40);
		cmd(8'hE9, 8);
		check(addr4_q, 1'b0);
		done("protect");
		cmd(8'h06, 8);
		cmd(8'h38, 8);
		check(quad_mode_q, 1'b1);
		byte_q.push_back(9'h0BE);
		byte_q.push_back(9'h0EF);
		op(sfc_pkg::OP_QPGM, 32'h0100_0300);
		host.frame({8'h32, 24'h000300, 16'hBEEF, 208'h0}, 48, 4, 0, rd);
		host.frame({8'hFF, 248'h0}, 8, 4, 0, rd);
		check(quad_mode_q, 1'b0);
		cmd(8'hF1, 8);
		check({write_enable_latch_q, deep_pd_q, addr4_q, status1_q, ext_addr_q}, 19'h0401);
		note_q.push_back(36'h8_0000_0000);
		cmd(8'h66, 8);
		cmd(8'h99, 8);
		cmd(8'h66, 8);
		cmd(8'h06, 8);
		cmd(8'h99, 8);
		check(note_q.size(), 0);
		done("quad and reset arm");
		cmd(8'h04, 8);
		cmd({8'h01, 8'h08}, 16);
		check({write_enable_latch_q, status1_q}, 9'h004);
		cmd(8'h50, 8);
		op(sfc_pkg::OP_SR, 32'h0);
		cmd({8'h01, 8'h00}, 16);
		check(status1_q, 8'h00);
		cmd(8'h06, 8);
		op(sfc_pkg::OP_SR, 32'h0);
		cmd({8'h31, 8'h21}, 16);
		cmd(8'h06, 8);
		op(sfc_pkg::OP_SR, 32'h0);
		cmd({8'hC0, 8'h42}, 16);
		check({status2_q, status3_q}, 16'h2142);
		cmd({8'hC5, 8'h3C}, 16);
		host.frame({8'hC8, 248'h0}, 8, 1, 8, rd);
		check(rd[7:0], 8'h3C);
		host.frame({8'h95, 248'h0}, 8, 1, 16, rd);
		check(rd[15:0], 16'h4242);
		check(byte_q.size(), 0);
		done("status writes");
		stop_test();
	end
endmodule // tb
